// File: include/fsq_map.svh
// Constants for the flash status and erase sequencer: command codes,
// status bit positions and timing counts.
// Assumes a 250 MHz system clock.
`ifndef FSQ_MAP_SVH
`define FSQ_MAP_SVH

// ********************************************************************
// Command codes
// ********************************************************************
`define FSQ_CMD_UNLOCK1 8'hAA
`define FSQ_CMD_UNLOCK2 8'h55
`define FSQ_CMD_PROGRAM 8'hA0
`define FSQ_CMD_ERASE_SETUP 8'h80
`define FSQ_CMD_BULK 8'h10
`define FSQ_CMD_SECTOR 8'h30
`define FSQ_CMD_BYPASS 8'h20
`define FSQ_CMD_BYPASS_EXIT1 8'h90
`define FSQ_CMD_BYPASS_EXIT2 8'h00

// ********************************************************************
// Status byte layout and widths
// ********************************************************************
`define FSQ_POLL_BIT 7
`define FSQ_TOGGLE_BIT 6
`define FSQ_ERROR_BIT 5
`define FSQ_WINDOW_BIT 3
`define FSQ_ADDR_W 16
`define FSQ_MAIN_ALL 8'hFF
`define FSQ_SEC_ALL 8'h0F
`define FSQ_RDATA_RESET 8'h00

// ********************************************************************
// Timing
// ********************************************************************
`define FSQ_CLK_PERIOD_PS 4000
`define FSQ_ERASE_WIN_US 80
`define FSQ_ERASE_WIN_CYCLES ((`FSQ_ERASE_WIN_US * 1000000) / `FSQ_CLK_PERIOD_PS)
`define FSQ_PROG_LIMIT_CYCLES 2000
`define FSQ_ERASE_LIMIT_CYCLES 250000
`define FSQ_TMR_W 24

`endif

// File: include/fsq_pkg.sv
// Types shared by the flash status and erase sequencer.
// Assumes fsq_map.svh supplies the widths.
`include "fsq_map.svh"

package fsq_pkg;

  // ******************************************************************
  // Sequencer states
  // ******************************************************************
  typedef enum logic [3:0] {
    FSQ_READ, FSQ_UNL1, FSQ_UNL2, FSQ_PGM_ADDR, FSQ_ERS1, FSQ_ERS2,
    FSQ_ERS3, FSQ_BYP_EXIT, FSQ_PROG, FSQ_SECT_WIN, FSQ_ERASE, FSQ_FAIL
  } fsq_state_t;

  // ******************************************************************
  // Control toward the flash cell arrays
  // ******************************************************************
  typedef struct packed {
    logic prog;
    logic erase;
    logic bulk;
    logic arr;
    logic [7:0] sect_mask;
    logic [`FSQ_ADDR_W-1:0] addr;
    logic [7:0] data;
  } fsq_cell_ctl_t;

endpackage

// File: src/fsq_flash_status_and_erase_sequencer.sv
// Program and erase sequencer for the two flash arrays with status reads.
// Assumes bus, sector selects and cell data all come from logic on clk_sys_in.
`timescale 1ns/1ps
`include "fsq_map.svh"

module fsq_flash_status_and_erase_sequencer import fsq_pkg::*; #(
  parameter int unsigned ERASE_WIN_CYCLES = `FSQ_ERASE_WIN_CYCLES,
  parameter int unsigned PROG_LIMIT_CYCLES = `FSQ_PROG_LIMIT_CYCLES,
  parameter int unsigned ERASE_LIMIT_CYCLES = `FSQ_ERASE_LIMIT_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [`FSQ_ADDR_W-1:0] bus_addr_in,
  input wire logic [7:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [7:0] bus_rdata_out,
  input wire logic [7:0] main_sector_select_in,
  input wire logic [3:0] secondary_sector_select_in,
  input wire logic [7:0] cell_rdata_in,
  input wire logic cell_verify_in,
  input wire logic ready_busy_enable_in,
  output fsq_cell_ctl_t cell_ctl_out,
  output logic ready_busy_pin_out,
  output logic ready_busy_pin_oe_out,
  output logic ready_busy_int_out
);

  // ******************************************************************
  // Elaboration checks
  // ******************************************************************
  if (ERASE_WIN_CYCLES < 1 || ERASE_WIN_CYCLES >= (1 << `FSQ_TMR_W) ||
      PROG_LIMIT_CYCLES < 1 || PROG_LIMIT_CYCLES >= (1 << `FSQ_TMR_W) ||
      ERASE_LIMIT_CYCLES < 1 || ERASE_LIMIT_CYCLES >= (1 << `FSQ_TMR_W)) begin : g_bad_count
    $error("fsq: timing count out of range");
  end

  // ******************************************************************
  // Functions
  // ******************************************************************
  function automatic logic [`FSQ_TMR_W-1:0] tmr_last(input int unsigned cyc);
    tmr_last = `FSQ_TMR_W'(cyc - 1);
  endfunction

  function automatic logic is_cmd(input logic [7:0] d, input logic [7:0] code);
    is_cmd = (d == code);
  endfunction

  // ******************************************************************
  // Decode of the current bus cycle
  // ******************************************************************
  fsq_state_t state_r;
  logic op_arr_r;
  logic [1:0] byp_r;
  logic [`FSQ_TMR_W-1:0] tmr_r;
  logic tog_r;
  logic fail_r;
  logic bulk_r;
  logic [7:0] mask_r;
  logic [7:0] data_r;
  logic [`FSQ_ADDR_W-1:0] addr_r;
  logic rb_r;
  logic prog_seq_r;

  logic any_sel;
  logic cur_arr;
  logic [7:0] cur_mask;
  logic op_hit;
  logic wr_go;
  logic wr_on;
  logic busy;
  logic status_mode;
  logic status_rd;
  logic bad_bits;
  logic prog_timeout;
  logic erase_timeout;
  logic win_expire;
  logic sect_add;
  logic [7:0] status_byte;

  assign any_sel = (|main_sector_select_in) | (|secondary_sector_select_in);
  // Secondary selects win only when no main select is active
  assign cur_arr = ~(|main_sector_select_in);
  assign cur_mask = cur_arr ? {4'h0, secondary_sector_select_in} : main_sector_select_in;
  assign op_hit = any_sel && (cur_arr == op_arr_r);
  assign wr_go = bus_wr_in && any_sel;
  assign wr_on = bus_wr_in && op_hit;
  assign busy = (state_r == FSQ_PROG) || (state_r == FSQ_SECT_WIN) ||
                (state_r == FSQ_ERASE);
  assign status_mode = busy || (state_r == FSQ_FAIL);
  assign status_rd = bus_rd_in && status_mode && op_hit;
  // A cleared cell cannot be set by programming
  assign bad_bits = |(bus_wdata_in & ~cell_rdata_in);
  assign prog_timeout = (state_r == FSQ_PROG) && !cell_verify_in &&
                        (tmr_r == tmr_last(PROG_LIMIT_CYCLES));
  assign erase_timeout = (state_r == FSQ_ERASE) && !cell_verify_in &&
                         (tmr_r == tmr_last(ERASE_LIMIT_CYCLES));
  assign win_expire = (state_r == FSQ_SECT_WIN) &&
                      (tmr_r == tmr_last(ERASE_WIN_CYCLES));
  assign sect_add = (state_r == FSQ_SECT_WIN) && wr_on &&
                    is_cmd(bus_wdata_in, `FSQ_CMD_SECTOR);

  // ******************************************************************
  // Instruction sequencer
  // ******************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      state_r <= FSQ_READ;
    end else begin
      case (state_r)
        FSQ_READ: begin
          if (wr_go) begin
            if (byp_r[cur_arr]) begin
              // Only the short program and the exit pair are heard
              if (is_cmd(bus_wdata_in, `FSQ_CMD_PROGRAM)) begin
                state_r <= FSQ_PGM_ADDR;
              end else if (is_cmd(bus_wdata_in, `FSQ_CMD_BYPASS_EXIT1)) begin
                state_r <= FSQ_BYP_EXIT;
              end
            end else if (is_cmd(bus_wdata_in, `FSQ_CMD_UNLOCK1)) begin
              state_r <= FSQ_UNL1;
            end
          end
        end
        FSQ_UNL1: begin
          if (wr_on) begin
            state_r <= is_cmd(bus_wdata_in, `FSQ_CMD_UNLOCK2) ? FSQ_UNL2 : FSQ_READ;
          end
        end
        FSQ_UNL2: begin
          if (wr_on) begin
            if (is_cmd(bus_wdata_in, `FSQ_CMD_PROGRAM)) begin
              state_r <= FSQ_PGM_ADDR;
            end else if (is_cmd(bus_wdata_in, `FSQ_CMD_ERASE_SETUP)) begin
              state_r <= FSQ_ERS1;
            end else begin
              state_r <= FSQ_READ;
            end
          end
        end
        FSQ_PGM_ADDR: begin
          if (wr_on) begin
            state_r <= bad_bits ? FSQ_FAIL : FSQ_PROG;
          end
        end
        FSQ_ERS1: begin
          if (wr_on) begin
            state_r <= is_cmd(bus_wdata_in, `FSQ_CMD_UNLOCK1) ? FSQ_ERS2 : FSQ_READ;
          end
        end
        FSQ_ERS2: begin
          if (wr_on) begin
            state_r <= is_cmd(bus_wdata_in, `FSQ_CMD_UNLOCK2) ? FSQ_ERS3 : FSQ_READ;
          end
        end
        FSQ_ERS3: begin
          if (wr_on) begin
            if (is_cmd(bus_wdata_in, `FSQ_CMD_BULK)) begin
              state_r <= FSQ_ERASE;
            end else if (is_cmd(bus_wdata_in, `FSQ_CMD_SECTOR)) begin
              state_r <= FSQ_SECT_WIN;
            end else begin
              state_r <= FSQ_READ;
            end
          end
        end
        FSQ_BYP_EXIT: begin
          if (wr_on) begin
            state_r <= FSQ_READ;
          end
        end
        FSQ_PROG: begin
          if (cell_verify_in) begin
            state_r <= FSQ_READ;
          end else if (prog_timeout) begin
            state_r <= FSQ_FAIL;
          end
        end
        FSQ_SECT_WIN: begin
          if (win_expire && !sect_add) begin
            state_r <= FSQ_ERASE;
          end
        end
        FSQ_ERASE: begin
          // Writes are not looked at here, so nothing can break in
          if (cell_verify_in) begin
            state_r <= FSQ_READ;
          end else if (erase_timeout) begin
            state_r <= FSQ_FAIL;
          end
        end
        // Failure holds its status until reset; the flash reset command
        // that would clear it lives elsewhere
        FSQ_FAIL: begin
          state_r <= FSQ_FAIL;
        end
        default: begin
          state_r <= FSQ_READ;
        end
      endcase
    end
  end

  // ******************************************************************
  // Target array of the running sequence
  // ******************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      op_arr_r <= 1'b0;
    end else if (state_r == FSQ_READ && wr_go) begin
      op_arr_r <= cur_arr;
    end
  end

  // ******************************************************************
  // Bypass mode flags, one per array
  // ******************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      byp_r <= 2'b00;
    end else if (state_r == FSQ_UNL2 && wr_on &&
                 is_cmd(bus_wdata_in, `FSQ_CMD_BYPASS)) begin
      byp_r[op_arr_r] <= 1'b1;
    end else if (state_r == FSQ_BYP_EXIT && wr_on &&
                 is_cmd(bus_wdata_in, `FSQ_CMD_BYPASS_EXIT2)) begin
      byp_r[op_arr_r] <= 1'b0;
    end
  end

  // ******************************************************************
  // Operation parameters
  // ******************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      addr_r <= '0;
      data_r <= 8'h00;
    end else if (state_r == FSQ_PGM_ADDR && wr_on) begin
      addr_r <= bus_addr_in;
      data_r <= bus_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      mask_r <= 8'h00;
      bulk_r <= 1'b0;
    end else if (state_r == FSQ_ERS3 && wr_on) begin
      bulk_r <= is_cmd(bus_wdata_in, `FSQ_CMD_BULK);
      if (is_cmd(bus_wdata_in, `FSQ_CMD_BULK)) begin
        mask_r <= op_arr_r ? `FSQ_SEC_ALL : `FSQ_MAIN_ALL;
      end else begin
        mask_r <= cur_mask;
      end
    end else if (sect_add) begin
      mask_r <= mask_r | cur_mask;
    end
  end

  // ******************************************************************
  // Timer for window and time limits
  // ******************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      tmr_r <= '0;
    end else if (!busy || sect_add || win_expire) begin
      // Each accepted 30h restarts the window
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + `FSQ_TMR_W'(1);
    end
  end

  // ******************************************************************
  // Status flags
  // ******************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      tog_r <= 1'b0;
    end else if (status_rd) begin
      tog_r <= ~tog_r;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      fail_r <= 1'b0;
    end else if ((state_r == FSQ_PGM_ADDR && wr_on && bad_bits) ||
                 prog_timeout || erase_timeout) begin
      fail_r <= 1'b1;
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[`FSQ_POLL_BIT] = (bulk_r || state_r == FSQ_SECT_WIN ||
                                  state_r == FSQ_ERASE || mask_r != 8'h00) &&
                                 (state_r != FSQ_PROG) && !prog_seq_r ? 1'b0 :
                                 ~data_r[7];
    status_byte[`FSQ_TOGGLE_BIT] = tog_r;
    status_byte[`FSQ_ERROR_BIT] = fail_r;
    status_byte[`FSQ_WINDOW_BIT] = (state_r != FSQ_SECT_WIN) && !prog_seq_r;
  end

  // Remembers whether the last operation was a program, for the poll bit
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      prog_seq_r <= 1'b0;
    end else if (state_r == FSQ_PGM_ADDR && wr_on) begin
      prog_seq_r <= 1'b1;
    end else if (state_r == FSQ_ERS3 && wr_on) begin
      prog_seq_r <= 1'b0;
    end
  end

  // ******************************************************************
  // Read data
  // ******************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      bus_rdata_out <= `FSQ_RDATA_RESET;
    end else if (status_rd) begin
      bus_rdata_out <= status_byte;
    end else if (bus_rd_in) begin
      bus_rdata_out <= cell_rdata_in;
    end else begin
      bus_rdata_out <= `FSQ_RDATA_RESET;
    end
  end

  // ******************************************************************
  // Ready/busy and cell control
  // ******************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rb_r <= 1'b1;
    end else begin
      rb_r <= ~busy;
    end
  end

  assign ready_busy_pin_out = rb_r;
  assign ready_busy_pin_oe_out = ready_busy_enable_in;
  // Internal copy ignores pin routing
  assign ready_busy_int_out = rb_r;

  assign cell_ctl_out.prog = (state_r == FSQ_PROG);
  assign cell_ctl_out.erase = (state_r == FSQ_ERASE);
  assign cell_ctl_out.bulk = bulk_r;
  assign cell_ctl_out.arr = op_arr_r;
  assign cell_ctl_out.sect_mask = mask_r;
  assign cell_ctl_out.addr = addr_r;
  assign cell_ctl_out.data = data_r;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  sequence s_status_rd;
    status_rd;
  endsequence

  chk_poll_prog_inv: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    s_status_rd and (state_r == FSQ_PROG) |=> bus_rdata_out[7] == ~data_r[7])
    else $error("poll bit not inverted during program");

  chk_poll_erase_zero: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    s_status_rd and (state_r == FSQ_ERASE) |=> bus_rdata_out[7] == 1'b0)
    else $error("poll bit not zero during erase");

  // Status reads with one idle cycle between them, as a polling host issues
  sequence s_spaced_status_rd;
    (status_rd && busy) ##1 !status_rd ##1 (status_rd && busy);
  endsequence

  chk_toggle_flip_run: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    s_spaced_status_rd |=> bus_rdata_out[6] != $past(bus_rdata_out[6], 2))
    else $error("toggle bit did not invert");

  chk_error_bad_bits: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == FSQ_PGM_ADDR && wr_on && bad_bits) |=> (state_r == FSQ_FAIL) && fail_r)
    else $error("zero-to-one program not flagged");

  chk_busy_pin_low: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    busy ##1 busy |-> !ready_busy_pin_out && !ready_busy_int_out)
    else $error("ready/busy high while busy");

  chk_bypass_entry: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == FSQ_UNL2 && wr_on && bus_wdata_in == `FSQ_CMD_BYPASS)
    |=> byp_r[op_arr_r] && state_r == FSQ_READ)
    else $error("bypass mode not entered");

  chk_bulk_whole_arr: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == FSQ_ERS3 && wr_on && bus_wdata_in == `FSQ_CMD_BULK)
    |=> state_r == FSQ_ERASE && mask_r == (op_arr_r ? `FSQ_SEC_ALL : `FSQ_MAIN_ALL))
    else $error("bulk erase mask wrong");

  chk_bulk_lockout: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (state_r == FSQ_ERASE && !cell_verify_in && !erase_timeout && bus_wr_in)
    |=> state_r == FSQ_ERASE)
    else $error("erase left on a write");

  chk_window_flag: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (status_rd && state_r == FSQ_SECT_WIN) |=> !bus_rdata_out[`FSQ_WINDOW_BIT])
    else $error("window flag set inside the window");

  chk_window_expiry: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (win_expire && !sect_add) |=> state_r == FSQ_ERASE && status_byte[`FSQ_WINDOW_BIT])
    else $error("window expiry wrong");

  chk_done_read_mode: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ((state_r == FSQ_PROG || state_r == FSQ_ERASE) && cell_verify_in)
    |=> state_r == FSQ_READ ##1 !status_mode)
    else $error("no return to read mode");

endmodule

// File: verification/fsq_cell_array_model.sv
// Behavioural flash cell array behind the sequencer's cell control.
// Assumes one clock; stall_in holds an operation so a limit timer runs out.
`timescale 1ns/1ps
module fsq_cell_array_model import fsq_pkg::*; #(
  parameter int PROG_DLY = 12,
  parameter int ERASE_DLY = 30
) (
  input wire logic clk_sys_in,
  input wire fsq_cell_ctl_t cell_ctl_in,
  input wire logic [15:0] rd_addr_in,
  input wire logic stall_in,
  output logic [7:0] cell_rdata_out,
  output logic cell_verify_out
);
  logic [7:0] mem_r [16];
  int cnt_r;

  initial begin
    foreach (mem_r[i]) mem_r[i] = 8'hFF;
    cnt_r = 0;
    cell_verify_out = 1'b0;
  end

  // Programming only clears bits; any erase restores every byte
  always @(posedge clk_sys_in) begin
    if (!(cell_ctl_in.prog || cell_ctl_in.erase)) begin
      cnt_r <= 0;
      cell_verify_out <= 1'b0;
    end else if (!stall_in && !cell_verify_out) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == (cell_ctl_in.prog ? PROG_DLY : ERASE_DLY)) begin
        cell_verify_out <= 1'b1;
        if (cell_ctl_in.prog) begin
          mem_r[cell_ctl_in.addr[3:0]] <= mem_r[cell_ctl_in.addr[3:0]] & cell_ctl_in.data;
        end else begin
          foreach (mem_r[i]) mem_r[i] <= 8'hFF;
        end
      end
    end
  end

  assign cell_rdata_out = mem_r[rd_addr_in[3:0]];
endmodule

// File: verification/tb.sv
// Self-checking bench for the flash status and erase sequencer.
// Assumes the cell array model answers program and erase unless stalled.
`timescale 1ns/1ps
module tb import fsq_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] msel = 8'h01;
  logic [3:0] ssel = 4'h0;
  logic rb_en = 1'b1;
  logic stall = 1'b0;
  logic [7:0] rdata;
  logic [7:0] cdata;
  logic cver;
  logic rb_pin;
  logic rb_oe;
  logic rb_int;
  logic [7:0] r;
  logic [7:0] q;
  fsq_cell_ctl_t ctl;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  // Short counts keep the run brief
  fsq_flash_status_and_erase_sequencer #(
    .ERASE_WIN_CYCLES(20), .PROG_LIMIT_CYCLES(16), .ERASE_LIMIT_CYCLES(40)
  ) i_dut (
    .clk_sys_in(clk), .reset_n_in(rst_n), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .main_sector_select_in(msel),
    .secondary_sector_select_in(ssel), .cell_rdata_in(cdata), .cell_verify_in(cver),
    .ready_busy_enable_in(rb_en), .cell_ctl_out(ctl), .ready_busy_pin_out(rb_pin),
    .ready_busy_pin_oe_out(rb_oe), .ready_busy_int_out(rb_int)
  );

  fsq_cell_array_model i_cells (
    .clk_sys_in(clk), .cell_ctl_in(ctl), .rd_addr_in(addr), .stall_in(stall),
    .cell_rdata_out(cdata), .cell_verify_out(cver)
  );

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_b(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    wr_b(16'h0000, 8'hAA);
    wr_b(16'h0000, 8'h55);
    wr_b(16'h0000, 8'hA0);
    wr_b(a, d);
  endtask

  task automatic seq6(input logic [7:0] fifth, input logic [7:0] last);
    wr_b(16'h0000, 8'hAA);
    wr_b(16'h0000, 8'h55);
    wr_b(16'h0000, 8'h80);
    wr_b(16'h0000, 8'hAA);
    wr_b(16'h0000, fifth);
    wr_b(16'h0000, last);
  endtask

  // Done once two reads in a row agree on the toggle bit
  task automatic wait_done(input logic [15:0] a);
    logic [7:0] r1;
    logic [7:0] r2;
    r1 = 8'h00;
    r2 = 8'h40;
    while (r1[6] !== r2[6]) begin
      rd_b(a, r1);
      rd_b(a, r2);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end

  // ****************************************************************
  // Scenarios; selects stay put through each poll
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_b(16'h0001, r);
    check(r, 8'hFF);
    check({5'h00, rb_oe, rb_pin, rb_int}, 8'h07);
    prog(16'h0001, 8'h5A);
    rd_b(16'h0001, r);
    check(r & 8'hA8, 8'h80);
    rd_b(16'h0001, q);
    check({7'h00, q[6]}, {7'h00, ~r[6]});
    check({6'h00, rb_pin, rb_int}, 8'h00);
    wait_done(16'h0001);
    rd_b(16'h0001, r);
    check(r, 8'h5A);
    wr_b(16'h0000, 8'hAA);
    wr_b(16'h0000, 8'h55);
    wr_b(16'h0000, 8'h20);
    wr_b(16'h0000, 8'hA0);
    wr_b(16'h0002, 8'hC3);
    rd_b(16'h0002, r);
    check(r & 8'hA0, 8'h00);
    wait_done(16'h0002);
    rd_b(16'h0002, r);
    check(r, 8'hC3);
    seq6(8'h55, 8'h10);
    rd_b(16'h0000, r);
    check(r, 8'hFF);
    wr_b(16'h0000, 8'h90);
    wr_b(16'h0000, 8'h00);
    wr_b(16'h0000, 8'hA0);
    wr_b(16'h0003, 8'h00);
    rd_b(16'h0003, r);
    check(r, 8'hFF);
    seq6(8'h77, 8'h10);
    rd_b(16'h0004, r);
    check(r, 8'hFF);
    @(posedge clk);
    msel <= 8'h00;
    ssel <= 4'h2;
    seq6(8'h55, 8'h10);
    rd_b(16'h0007, r);
    check(r & 8'hA8, 8'h08);
    rd_b(16'h0007, q);
    check({7'h00, q[6]}, {7'h00, ~r[6]});
    check({6'h00, ctl.bulk, ctl.arr}, 8'h03);
    prog(16'h0005, 8'h00);
    wait_done(16'h0007);
    rd_b(16'h0005, r);
    check(r, 8'hFF);
    @(posedge clk);
    msel <= 8'h04;
    ssel <= 4'h0;
    seq6(8'h55, 8'h30);
    rd_b(16'h0009, r);
    check(r & 8'h88, 8'h00);
    @(posedge clk);
    msel <= 8'h08;
    wr_b(16'h0009, 8'h30);
    // Window is 20 cycles after the last sector command
    repeat (24) @(posedge clk);
    rd_b(16'h0009, r);
    check(r & 8'h88, 8'h08);
    check(ctl.sect_mask, 8'h0C);
    wait_done(16'h0009);
    @(posedge clk);
    msel <= 8'h01;
    stall <= 1'b1;
    seq6(8'h55, 8'h10);
    repeat (50) @(posedge clk);
    rd_b(16'h0000, r);
    check(r & 8'hA0, 8'h20);
    check({7'h00, rb_int}, 8'h01);
    // Only a reset clears the failed state
    @(posedge clk);
    rst_n <= 1'b0;
    stall <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    prog(16'h0006, 8'h00);
    wait_done(16'h0006);
    prog(16'h0006, 8'h01);
    rd_b(16'h0006, r);
    check(r & 8'hA0, 8'hA0);
    rd_b(16'h0006, q);
    check(q & 8'hA0, 8'hA0);
    // Program that never verifies runs into the time limit
    @(posedge clk);
    rst_n <= 1'b0;
    stall <= 1'b1;
    @(posedge clk);
    rst_n <= 1'b1;
    prog(16'h0008, 8'h0F);
    repeat (20) @(posedge clk);
    rd_b(16'h0008, r);
    check(r & 8'hA0, 8'hA0);
    @(posedge clk);
    rb_en <= 1'b0;
    @(posedge clk);
    #1;
    check({6'h00, rb_oe, rb_pin}, 8'h01);
    results();
  end
endmodule
